/* File: shared/rps_pkg.sv */
// constants, field layout and types shared by the remappable pin-select unit
package rps_pkg;

	// register set size and field geometry
	localparam int RPS_NUM_IN_REGS = 20;
	localparam int RPS_NUM_OUT_REGS = 16;
	localparam int RPS_CODE_W = 6;
	localparam int RPS_CODE_SPACE = 64;
	localparam int RPS_NUM_IN_PINS = 44;
	localparam int RPS_NUM_IO_PINS = 32;
	localparam int RPS_LO_LSB = 0;
	localparam int RPS_HI_LSB = 8;

	// byte addresses on the register bus
	localparam logic [11:0] RPS_IN_BASE = 12'h000;
	localparam logic [11:0] RPS_OUT_BASE = 12'h080;
	localparam logic [11:0] RPS_OSC_ADDR = 12'h0c0;
	localparam logic [11:0] RPS_CFG_ADDR = 12'h0c4;

	// unlock keys, bit positions and reset values
	localparam logic [7:0] RPS_KEY_FIRST = 8'h46;
	localparam logic [7:0] RPS_KEY_SECOND = 8'h57;
	localparam int RPS_LOCK_BIT = 6;
	localparam int RPS_FUSE_BIT = 4;
	localparam logic [5:0] RPS_IN_RST = 6'h3f;
	localparam logic [5:0] RPS_OUT_RST = 6'h00;
	localparam logic [5:0] RPS_NULL_FN = 6'h00;
	localparam logic RPS_LOCK_RST = 1'b0;

	// one select register: two six-bit fields
	typedef struct packed {
		logic [5:0] hi;
		logic [5:0] lo;
	} rps_sel_pair_t;

	// unlock sequence progress
	typedef enum logic [2:0] {
		RPS_SEQ_IDLE = 3'b001,
		RPS_SEQ_KEY1 = 3'b010,
		RPS_SEQ_ARMED = 3'b100
	} rps_seq_t;

endpackage : rps_pkg

/* File: hw/rps_pin_select.sv */
// remappable pin-select unit with write lock, unlock sequence and shadow monitor
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none

// overview
// software reaches the select registers, the oscillator control lock and a mirror
// of configuration word two over a zero-wait register bus
// input fields pick one pin per peripheral input; output fields pick one
// peripheral output per pin, so fan-out both ways costs nothing extra
// the lock gates every select write; the key detector sits on the bus write
// stream and aborts on any write that is not the next expected one, save a repeated first key, which restarts it
// shadows are written in the same cycle as the primaries, so the monitor
// only sees a difference if a stored bit is disturbed afterwards
// limitation: contention between two inputs on one field cannot occur, since
// each field holds a single code; apart from locked and unaligned writes, only writes to output fields of missing pins are refused

module rps_pin_select
	import rps_pkg::*;
#(
	parameter int NUM_IN_PINS = RPS_NUM_IN_PINS,
	parameter logic [63:0] IN_PIN_MASK = 64'h0000_0fff_ffff_ffff,
	parameter logic [31:0] IO_PIN_MASK = 32'hffff_ffff
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] configWordTwo,
	input wire logic [NUM_IN_PINS-1:0] pinIn,
	input wire logic [NUM_IN_PINS-1:0] pinAnalog,
	output logic [2*RPS_NUM_IN_REGS-1:0] periphIn,
	input wire logic [RPS_CODE_SPACE-1:0] periphOut,
	output logic [RPS_NUM_IO_PINS-1:0] pinOut,
	output logic [RPS_NUM_IO_PINS-1:0] pinOutEn,
	output logic pinMapWriteLock,
	output logic cfgMismatchReset
);

	localparam int NUM_IN_FIELDS = 2 * RPS_NUM_IN_REGS;

	// refuse pin counts that the six-bit code space cannot address
	if (NUM_IN_PINS < RPS_NUM_IO_PINS || NUM_IN_PINS > RPS_CODE_SPACE) begin : g_bad_pins
		$error("rps_pin_select: NUM_IN_PINS must lie between 32 and 64");
	end

	// each output register serves exactly two pins
	if (2 * RPS_NUM_OUT_REGS != RPS_NUM_IO_PINS) begin : g_bad_out
		$error("rps_pin_select: output registers must cover two pins each");
	end

	// register state
	rps_sel_pair_t inSel_reg [RPS_NUM_IN_REGS];
	rps_sel_pair_t inShadow_reg [RPS_NUM_IN_REGS];
	rps_sel_pair_t outSel_reg [RPS_NUM_OUT_REGS];
	rps_sel_pair_t outShadow_reg [RPS_NUM_OUT_REGS];
	logic lock_reg;
	logic lock_next;
	rps_seq_t seq_reg;
	rps_seq_t seq_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic mismatch_reg;

	// bus decode
	// pready is tied high, so every transfer ends after a single access cycle
	wire logic setupPhase = psel & ~penable;
	wire logic accessPhase = psel & penable;
	wire logic wrEn = accessPhase & pwrite;
	wire logic inRange = (paddr >= RPS_IN_BASE) && (paddr < RPS_IN_BASE + 12'(4 * RPS_NUM_IN_REGS));
	wire logic outRange = (paddr >= RPS_OUT_BASE) && (paddr < RPS_OUT_BASE + 12'(4 * RPS_NUM_OUT_REGS));
	wire logic oscHit = paddr == RPS_OSC_ADDR;
	wire logic cfgHit = paddr == RPS_CFG_ADDR;
	wire logic aligned = paddr[1:0] == 2'b00;
	wire logic addrHit = aligned & (inRange | outRange | oscHit | cfgHit);
	wire logic [4:0] inIdx = 5'((paddr - RPS_IN_BASE) >> 2);
	wire logic [3:0] outIdx = 4'((paddr - RPS_OUT_BASE) >> 2);
	wire logic oscLowWr = wrEn & oscHit & aligned & pstrb[0];
	wire logic [7:0] oscByte = pwdata[7:0];

	// single-session fuse comes straight from configuration word two
	wire logic fuseOneWay = configWordTwo[RPS_FUSE_BIT];

	// a clear lock with the fuse active may still be set once, closing the one write session
	// a locked map with the fuse active ignores keys and lock writes
	wire logic frozen = fuseOneWay & lock_reg;

	// select writes pass only while the lock is clear
	wire logic selWrOk = wrEn & aligned & ~lock_reg;

	// zero wait states: read data is flopped in setup so pready stays high
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~addrHit;
	assign prdata = rdata_reg;
	assign pinMapWriteLock = lock_reg;
	assign cfgMismatchReset = mismatch_reg;

	// unlock sequence: keys must arrive on consecutive bus writes
	// keys and lock write need pstrb[0]; a write with the low lane off counts
	// as an intervening write and drops the sequence
	always_comb begin
		seq_next = seq_reg;
		lock_next = lock_reg;
		if (wrEn) begin
			unique case (seq_reg)
				RPS_SEQ_IDLE: begin
					seq_next = (oscLowWr && oscByte == RPS_KEY_FIRST && !frozen) ? RPS_SEQ_KEY1 : RPS_SEQ_IDLE;
				end
				RPS_SEQ_KEY1: begin
					if (oscLowWr && oscByte == RPS_KEY_SECOND && !frozen) begin
						seq_next = RPS_SEQ_ARMED;
					end else if (oscLowWr && oscByte == RPS_KEY_FIRST && !frozen) begin
						seq_next = RPS_SEQ_KEY1;
					end else begin
						seq_next = RPS_SEQ_IDLE;
					end
				end
				RPS_SEQ_ARMED: begin
					// only this very write may move the lock; anything else just aborts
					seq_next = RPS_SEQ_IDLE;
					if (oscLowWr && !frozen) begin
						lock_next = oscByte[RPS_LOCK_BIT];
					end
				end
			endcase
		end
	end

	// lock and sequence flops; the lock otherwise holds its value
	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_reg <= RPS_LOCK_RST;
			seq_reg <= RPS_SEQ_IDLE;
		end else begin
			lock_reg <= lock_next;
			seq_reg <= seq_next;
		end
	end

	// input-select registers with their shadows, one per generate entry
	for (genvar i = 0; i < RPS_NUM_IN_REGS; i++) begin : g_in_reg
		wire logic hit = selWrOk & inRange & (inIdx == 5'(i));
		always_ff @(posedge mclk) begin
			if (rst) begin
				// the top code loads even though no such pin exists
				inSel_reg[i] <= '{hi: RPS_IN_RST, lo: RPS_IN_RST};
				inShadow_reg[i] <= '{hi: RPS_IN_RST, lo: RPS_IN_RST};
			end else if (hit) begin
				if (pstrb[0]) begin
					inSel_reg[i].lo <= pwdata[RPS_LO_LSB +: RPS_CODE_W];
					inShadow_reg[i].lo <= pwdata[RPS_LO_LSB +: RPS_CODE_W];
				end
				if (pstrb[1]) begin
					inSel_reg[i].hi <= pwdata[RPS_HI_LSB +: RPS_CODE_W];
					inShadow_reg[i].hi <= pwdata[RPS_HI_LSB +: RPS_CODE_W];
				end
			end
		end
	end

	// output-select registers: two pins each, missing pins keep the null code
	for (genvar j = 0; j < RPS_NUM_OUT_REGS; j++) begin : g_out_reg
		wire logic hit = selWrOk & outRange & (outIdx == 4'(j));
		wire logic loOk = hit & pstrb[0] & IO_PIN_MASK[2*j];
		wire logic hiOk = hit & pstrb[1] & IO_PIN_MASK[2*j+1];
		always_ff @(posedge mclk) begin
			if (rst) begin
				outSel_reg[j] <= '{hi: RPS_OUT_RST, lo: RPS_OUT_RST};
				outShadow_reg[j] <= '{hi: RPS_OUT_RST, lo: RPS_OUT_RST};
			end else begin
				if (loOk) begin
					outSel_reg[j].lo <= pwdata[RPS_LO_LSB +: RPS_CODE_W];
					outShadow_reg[j].lo <= pwdata[RPS_LO_LSB +: RPS_CODE_W];
				end
				if (hiOk) begin
					outSel_reg[j].hi <= pwdata[RPS_HI_LSB +: RPS_CODE_W];
					outShadow_reg[j].hi <= pwdata[RPS_HI_LSB +: RPS_CODE_W];
				end
			end
		end
	end

	// continuous shadow comparison; a disturbed cell shows up as a difference
	// trade-off: a second copy doubles the select storage, but a single upset
	// cell is caught within one clock instead of silently remapping a pin
	logic [RPS_NUM_IN_REGS-1:0] inDiff;
	logic [RPS_NUM_OUT_REGS-1:0] outDiff;
	for (genvar i = 0; i < RPS_NUM_IN_REGS; i++) begin : g_in_cmp
		assign inDiff[i] = inSel_reg[i] != inShadow_reg[i];
	end
	for (genvar j = 0; j < RPS_NUM_OUT_REGS; j++) begin : g_out_cmp
		assign outDiff[j] = outSel_reg[j] != outShadow_reg[j];
	end

	// mismatch request is a level held while any copy disagrees
	always_ff @(posedge mclk) begin
		if (rst) begin
			mismatch_reg <= 1'b0;
		end else begin
			mismatch_reg <= (|inDiff) | (|outDiff);
		end
	end

	// pin levels padded to the full code space; analog pins read low digitally
	wire logic [RPS_CODE_SPACE-1:0] pinLevel = RPS_CODE_SPACE'(pinIn & ~pinAnalog);
	wire logic [RPS_CODE_SPACE-1:0] codeValid = IN_PIN_MASK & RPS_CODE_SPACE'({NUM_IN_PINS{1'b1}});

	// input routing: a pin may feed any number of peripheral inputs
	logic [NUM_IN_FIELDS-1:0] periphIn_next;
	for (genvar f = 0; f < NUM_IN_FIELDS; f++) begin : g_in_route
		wire logic [5:0] code = ((f % 2) == 1) ? inSel_reg[f/2].hi : inSel_reg[f/2].lo;
		// invalid codes, the reset code among them, tie the input to ground
		assign periphIn_next[f] = codeValid[code] & pinLevel[code];
	end

	// output routing: one peripheral output may drive several pins
	logic [RPS_NUM_IO_PINS-1:0] pinOut_next;
	logic [RPS_NUM_IO_PINS-1:0] pinOutEn_next;
	for (genvar p = 0; p < RPS_NUM_IO_PINS; p++) begin : g_out_route
		wire logic [5:0] code = ((p % 2) == 1) ? outSel_reg[p/2].hi : outSel_reg[p/2].lo;
		// a code whose peripheral output is unused simply drives low
		wire logic live = (code != RPS_NULL_FN) & IO_PIN_MASK[p];
		assign pinOut_next[p] = live & periphOut[code];
		// a live code enables the pin driver unless the pin is flagged analog
		assign pinOutEn_next[p] = live & ~pinAnalog[p];
	end

	// routed data is flopped so the pins see clean registered levels
	always_ff @(posedge mclk) begin
		if (rst) begin
			periphIn <= '0;
			pinOut <= '0;
			pinOutEn <= '0;
		end else begin
			periphIn <= periphIn_next;
			pinOut <= pinOut_next;
			pinOutEn <= pinOutEn_next;
		end
	end

	// read mux: select fields in low lanes, unused bits read zero
	// unaligned addresses read zero even when the word bits would hit a register
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (inRange) begin
			rdata_next[RPS_LO_LSB +: RPS_CODE_W] = inSel_reg[inIdx].lo;
			rdata_next[RPS_HI_LSB +: RPS_CODE_W] = inSel_reg[inIdx].hi;
		end else if (outRange) begin
			rdata_next[RPS_LO_LSB +: RPS_CODE_W] = outSel_reg[outIdx].lo;
			rdata_next[RPS_HI_LSB +: RPS_CODE_W] = outSel_reg[outIdx].hi;
		end else if (oscHit) begin
			rdata_next[RPS_LOCK_BIT] = lock_reg;
		end else if (cfgHit) begin
			rdata_next[15:0] = configWordTwo;
		end
		if (!aligned) begin
			rdata_next = 32'h0000_0000;
		end
	end

	// capture read data during setup; hold it through the access phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setupPhase) begin
			rdata_reg <= rdata_next;
		end
	end

endmodule : rps_pin_select
`default_nettype wire

/* File: tb/rps_periph_model.sv */
// peripheral and pad side model: pin levels, analog flags, peripheral outputs
`timescale 1ns/1ns
`default_nettype none
module rps_periph_model
	import rps_pkg::*;
(
	input wire logic mclk,
	input wire logic [5:0] fnCode,
	input wire logic [43:0] pinLvl,
	input wire logic [43:0] anaLvl,
	output logic [63:0] periphOut,
	output logic [43:0] pinIn,
	output logic [43:0] pinAnalog
);
	// one function drives high; slot zero stays quiet since it is the null source
	always_ff @(posedge mclk) begin
		periphOut <= (64'h1 << fnCode) & ~64'h1;
		pinIn <= pinLvl;
		pinAnalog <= anaLvl;
	end
endmodule : rps_periph_model
`default_nettype wire

/* File: tb/rps_pin_select_properties.sv */
// concurrent checks on the pin-select unit ports
`timescale 1ns/1ns
`default_nettype none
module rps_pin_select_chk
	import rps_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [15:0] configWordTwo,
	input wire logic [31:0] pinOutEn,
	input wire logic pinMapWriteLock,
	input wire logic cfgMismatchReset
);
	logic [7:0] k1Reg;
	logic [7:0] k2Reg;
	wire logic wrAcc = psel && penable && pwrite;
	wire logic newLock = pwdata[RPS_LOCK_BIT];
	wire logic selAcc = psel && penable && paddr < 12'h050;
	// fuse with a set lock freezes it, so keys then count for nothing
	wire logic keyed = wrAcc && paddr == RPS_OSC_ADDR && k2Reg == RPS_KEY_FIRST
		&& k1Reg == RPS_KEY_SECOND && !(configWordTwo[RPS_FUSE_BIT] && pinMapWriteLock);
	// low bytes of the last two writes; a write elsewhere breaks the chain
	always_ff @(posedge mclk) begin
		if (rst) begin
			k1Reg <= 8'h00;
			k2Reg <= 8'h00;
		end else if (wrAcc) begin
			k1Reg <= (paddr == RPS_OSC_ADDR) ? pwdata[7:0] : 8'h00;
			k2Reg <= k1Reg;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence keyedWrite;
		keyed;
	endsequence
	sequence lockFollows;
		pinMapWriteLock == $past(newLock);
	endsequence
	lock_write_a: assert property (keyedWrite |=> lockFollows)
		else $error("lock missed keyed write");
	lock_hold_a: assert property (!keyed |=> $stable(pinMapWriteLock))
		else $error("lock moved without keys");
	fuse_keep_a: assert property (pinMapWriteLock && configWordTwo[RPS_FUSE_BIT] |=> pinMapWriteLock)
		else $error("fused lock cleared");
	rst_lock_a: assert property ($fell(rst) |-> !pinMapWriteLock)
		else $error("lock set after reset");
	rst_outen_a: assert property ($fell(rst) |-> pinOutEn == 32'h0)
		else $error("pin driven after reset");
	sel_ok_a: assert property (selAcc |-> !pslverr)
		else $error("select access errored");
	lock_read_a: assert property (psel && penable && paddr == RPS_OSC_ADDR |-> prdata[6] == pinMapWriteLock)
		else $error("lock bit misread");
	shadow_ok_a: assert property (selAcc |=> !cfgMismatchReset)
		else $error("shadow mismatch raised");
endmodule : rps_pin_select_chk

bind rps_pin_select rps_pin_select_chk chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.configWordTwo(configWordTwo), .pinOutEn(pinOutEn), .pinMapWriteLock(pinMapWriteLock),
	.cfgMismatchReset(cfgMismatchReset));
`default_nettype wire

/* File: tb/test_rps_pin_select.sv */
// self-checking bench for the pin-select unit
`timescale 1ns/1ns
`default_nettype none
module test_rps_pin_select
	import rps_pkg::*;
;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, lock, mis;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, pinOut, pinOutEn;
	logic [15:0] configWordTwo;
	logic [5:0] fnCode;
	logic [43:0] pinLvl, anaLvl, pinIn, pinAna;
	logic [39:0] periphIn;
	logic [63:0] periphOut;
	int n_fail, tests_run;
	// pin 31 left out to exercise an unimplemented output field
	rps_pin_select #(.IO_PIN_MASK(32'h7fff_ffff)) DUT (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .configWordTwo(configWordTwo), .pinIn(pinIn), .pinAnalog(pinAna),
		.periphIn(periphIn), .periphOut(periphOut), .pinOut(pinOut), .pinOutEn(pinOutEn),
		.pinMapWriteLock(lock), .cfgMismatchReset(mis));
	rps_periph_model model (.mclk(mclk), .fnCode(fnCode), .pinLvl(pinLvl), .anaLvl(anaLvl),
		.periphOut(periphOut), .pinIn(pinIn), .pinAnalog(pinAna));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// one transfer; the wait for pready is bounded so a hang cannot stall the run
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			test_done();
		end
	endtask : bus
	task automatic lockSeq(input logic [31:0] v);
		bus(1'b1, RPS_OSC_ADDR, 32'h46);
		bus(1'b1, RPS_OSC_ADDR, 32'h57);
		bus(1'b1, RPS_OSC_ADDR, v);
	endtask : lockSeq
	task automatic rstDev();
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
	endtask : rstDev
	task automatic tReset();
		bus(1'b0, 12'h04c, 32'h0);
		chk(rd, 32'h3f3f, "in19");
		chk(periphIn, 40'h0, "periph in");
		bus(1'b0, 12'h050, 32'h0);
		chk(er, 1'b1, "unmapped");
	endtask : tReset
	// fan-out both ways, invalid code, missing pin, analog pin, null output
	task automatic tRoute();
		pinLvl <= 44'h800_0000_0020;
		fnCode <= 6'h03;
		bus(1'b1, RPS_IN_BASE, 32'h0505);
		bus(1'b1, 12'h004, 32'h2c2b);
		bus(1'b1, RPS_OUT_BASE, 32'h0303);
		bus(1'b1, 12'h0bc, 32'h0303);
		anaLvl <= 44'h1;
		repeat (3) @(posedge mclk);
		chk(periphIn[3:0], 4'h7, "fan in");
		chk({pinOutEn[31:30], pinOutEn[1:0], pinOut[1]}, 5'h0d, "fan out");
		bus(1'b1, RPS_OUT_BASE, 32'h0);
		repeat (2) @(posedge mclk);
		chk(pinOutEn[1:0], 2'h0, "null");
	endtask : tRoute
	// locked writes vanish, a broken key chain fails, one unlock serves many writes
	task automatic tLock();
		lockSeq(32'h40);
		bus(1'b1, RPS_IN_BASE, 32'h0101);
		chk(er, 1'b0, "locked err");
		bus(1'b0, RPS_IN_BASE, 32'h0);
		chk(rd, 32'h0505, "locked in0");
		bus(1'b1, RPS_OSC_ADDR, 32'h46);
		bus(1'b1, RPS_OSC_ADDR, 32'h57);
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, RPS_OSC_ADDR, 32'h0);
		bus(1'b0, RPS_OSC_ADDR, 32'h0);
		chk(rd[6], 1'b1, "aborted");
		lockSeq(32'h0);
		bus(1'b1, RPS_IN_BASE, 32'h0101);
		bus(1'b1, 12'h004, 32'h0202);
		bus(1'b0, RPS_IN_BASE, 32'h0);
		chk(rd, 32'h0101, "in0");
	endtask : tLock
	task automatic tFuse();
		configWordTwo <= 16'h0010;
		bus(1'b0, RPS_CFG_ADDR, 32'h0);
		chk(rd[4], 1'b1, "fuse");
		lockSeq(32'h40);
		lockSeq(32'h0);
		chk(lock, 1'b1, "fused");
		rstDev();
		bus(1'b0, RPS_OSC_ADDR, 32'h0);
		chk(rd[6], 1'b0, "reset lock");
		chk(mis, 1'b0, "mismatch");
	endtask : tFuse
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{configWordTwo, fnCode, pinLvl, anaLvl} = '0;
		n_fail = 0;
		tests_run = 0;
		rstDev();
		tReset();
		tRoute();
		tLock();
		tFuse();
		test_done();
	end
endmodule : test_rps_pin_select
`default_nettype wire
